/* rtl/dtcal_pkg.sv */
// dtcal_pkg: command codes, reset values, field layouts and word-format helpers
package dtcal_pkg;

	// ********************************************
	// command codes of the register group
	// ********************************************
	localparam logic [7:0] DTCAL_CMD_DEAD_TIME_LIMIT = 8'hbf;
	localparam logic [7:0] DTCAL_CMD_PHASE0_SENSE_GAIN = 8'hca;
	localparam logic [7:0] DTCAL_CMD_PHASE1_SENSE_GAIN = 8'hcb;
	localparam logic [7:0] DTCAL_CMD_PHASE0_CURRENT_OFFSET = 8'hcc;
	localparam logic [7:0] DTCAL_CMD_PHASE1_CURRENT_OFFSET = 8'hcd;
	localparam logic [7:0] DTCAL_CMD_RAMP_FLOOR_VOLTAGE = 8'hce;

	// ********************************************
	// values after reset
	// ********************************************
	localparam logic [15:0] DTCAL_RST_DEAD_TIME_LIMIT = 16'h3838;
	localparam logic [15:0] DTCAL_RST_SENSE_GAIN = 16'haa66;
	localparam logic [15:0] DTCAL_RST_CURRENT_OFFSET = 16'h0000;
	localparam logic [15:0] DTCAL_RST_RAMP_FLOOR_VOLTAGE = 16'hf258;

	// ********************************************
	// field layouts
	// ********************************************
	localparam int DTCAL_DT_HL_MSB = 14;
	localparam int DTCAL_DT_HL_LSB = 8;
	localparam int DTCAL_DT_LH_MSB = 6;
	localparam int DTCAL_DT_LH_LSB = 0;
	localparam logic [15:0] DTCAL_DT_USED_MASK = 16'h7f7f;
	localparam logic [6:0] DTCAL_DT_RANGE_MAX_NS = 7'h3c;
	localparam int DTCAL_EXP_MSB = 15;
	localparam int DTCAL_EXP_LSB = 11;
	localparam int DTCAL_MANT_MSB = 10;
	localparam int DTCAL_MANT_LSB = 0;

	// ********************************************
	// arithmetic constants
	// ********************************************
	localparam int DTCAL_FRAC_BITS = 8;
	localparam logic signed [6:0] DTCAL_FRAC_SHIFT = 7'sh08;
	localparam logic signed [15:0] DTCAL_MA_PER_A = 16'sh03e8;
	localparam logic [5:0] DTCAL_DIV_STEPS = 6'h20;
	localparam int DTCAL_PHASES = 2;

	// fixed point with DTCAL_FRAC_BITS fraction bits, sign kept
	function automatic logic signed [39:0] dtcal_lin11_to_fix(input logic [15:0] w);
		logic signed [6:0] s;
		logic signed [39:0] y;
		s = {{2{w[DTCAL_EXP_MSB]}}, w[DTCAL_EXP_MSB:DTCAL_EXP_LSB]} + DTCAL_FRAC_SHIFT;
		y = {{29{w[DTCAL_MANT_MSB]}}, w[DTCAL_MANT_MSB:DTCAL_MANT_LSB]};
		if (s >= 7'sh00) begin
			return y <<< s[5:0];
		end
		return y >>> 6'(-s);
	endfunction : dtcal_lin11_to_fix

endpackage : dtcal_pkg

/* rtl/dtcal_phase_if.sv */
// dtcal_phase_if: per-phase link between register bank and current calculator
`timescale 1ns/1ps
interface dtcal_phase_if;
	logic start;
	logic signed [15:0] sense_uv;
	logic [15:0] gain_word;
	logic [15:0] offset_word;
	logic busy;
	logic done;
	logic fault;
	logic signed [31:0] current_ma;

	modport ctrl (output start, output sense_uv, output gain_word, output offset_word,
		input busy, input done, input fault, input current_ma);
	modport calc (input start, input sense_uv, input gain_word, input offset_word,
		output busy, output done, output fault, output current_ma);
endinterface : dtcal_phase_if

/* rtl/dtcal_phase_calc.sv */
// dtcal_phase_calc: output current of one phase from sense voltage, gain and offset
`timescale 1ns/1ps
module dtcal_phase_calc (
	input wire logic clk,
	input wire logic srst,
	dtcal_phase_if.calc pif
);
	import dtcal_pkg::*;

	typedef enum logic [1:0] {DTCAL_IDLE, DTCAL_DIVIDE, DTCAL_FINISH} dtcal_calc_state_type;

	dtcal_calc_state_type state_q;
	logic [5:0] step_q;
	logic [32:0] rem_q;
	logic [31:0] quo_q;
	logic [31:0] den_q;
	logic neg_q;
	logic signed [55:0] off_ma_q;
	logic busy_q;
	logic done_q;
	logic fault_q;
	logic signed [31:0] current_q;
	logic signed [39:0] gain_fix;
	logic signed [39:0] off_fix;
	logic [32:0] rem_sh;
	logic signed [55:0] total;

	assign gain_fix = dtcal_lin11_to_fix(pif.gain_word);
	assign off_fix = dtcal_lin11_to_fix(pif.offset_word);
	assign rem_sh = {rem_q[31:0], quo_q[31]};
	assign total = (neg_q ? -$signed({24'h000000, quo_q}) : $signed({24'h000000, quo_q})) + off_ma_q;

	// ********************************************
	// restoring divider, one quotient bit a cycle
	// ********************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			state_q <= DTCAL_IDLE;
			step_q <= 6'h00;
			rem_q <= 33'h000000000;
			quo_q <= 32'h00000000;
			den_q <= 32'h00000000;
			neg_q <= 1'b0;
			off_ma_q <= 56'sh0;
		end else begin
			case (state_q)
				DTCAL_IDLE: begin
					if (pif.start) begin
						// uV over milliohm gives mA; numerator carries the gain's fraction plus our own
						neg_q <= pif.sense_uv[15];
						quo_q <= {(pif.sense_uv[15] ? 16'(-pif.sense_uv) : pif.sense_uv), 16'h0000};
						rem_q <= 33'h000000000;
						den_q <= (gain_fix[39:32] != 8'h00) ? 32'hffffffff : gain_fix[31:0];
						off_ma_q <= 56'(off_fix) * 56'(DTCAL_MA_PER_A);
						step_q <= 6'h00;
						state_q <= DTCAL_DIVIDE;
					end
				end
				DTCAL_DIVIDE: begin
					if (rem_sh >= {1'b0, den_q}) begin
						rem_q <= rem_sh - {1'b0, den_q};
						quo_q <= {quo_q[30:0], 1'b1};
					end else begin
						rem_q <= rem_sh;
						quo_q <= {quo_q[30:0], 1'b0};
					end
					step_q <= step_q + 6'h01;
					if (step_q == DTCAL_DIV_STEPS - 6'h01) begin
						state_q <= DTCAL_FINISH;
					end
				end
				DTCAL_FINISH: begin
					state_q <= DTCAL_IDLE;
				end
				default: begin
					state_q <= DTCAL_IDLE;
				end
			endcase
		end
	end

	// ********************************************
	// result and handshake
	// ********************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			busy_q <= 1'b0;
			done_q <= 1'b0;
			fault_q <= 1'b0;
			current_q <= 32'sh0;
		end else begin
			done_q <= 1'b0;
			if (state_q == DTCAL_IDLE && pif.start) begin
				busy_q <= 1'b1;
			end
			if (state_q == DTCAL_FINISH) begin
				busy_q <= 1'b0;
				done_q <= 1'b1;
				// a zero or negative gain cannot scale; report offset only and flag it
				fault_q <= (den_q == 32'h00000000) || den_q[31];
				current_q <= (den_q == 32'h00000000 || den_q[31]) ? 32'(off_ma_q >>> DTCAL_FRAC_BITS)
					: 32'(total >>> DTCAL_FRAC_BITS);
			end
		end
	end

	assign pif.busy = busy_q;
	assign pif.done = done_q;
	assign pif.fault = fault_q;
	assign pif.current_ma = current_q;

endmodule : dtcal_phase_calc

/* rtl/dtcal_regs.sv */
// dtcal_regs: dead-time limit, per-phase current calibration and ramp floor register group
`timescale 1ns/1ps
module dtcal_regs (
	input wire logic clk,
	input wire logic srst,
	input wire logic [7:0] cmd_code,
	input wire logic cmd_wr,
	input wire logic cmd_rd,
	input wire logic [15:0] cmd_wdata,
	input wire logic write_protect,
	output logic [15:0] cmd_rdata,
	output logic cmd_rvalid,
	output logic cmd_ack,
	output logic cmd_nack,
	input wire logic adapt_en,
	input wire logic [6:0] adapt_hl_ns,
	input wire logic [6:0] adapt_lh_ns,
	output logic [6:0] dt_hl_ns,
	output logic [6:0] dt_lh_ns,
	input wire logic sense_strobe,
	input wire logic [dtcal_pkg::DTCAL_PHASES-1:0][15:0] sense_uv,
	output logic [dtcal_pkg::DTCAL_PHASES-1:0][31:0] current_ma,
	output logic [dtcal_pkg::DTCAL_PHASES-1:0] current_valid,
	output logic [dtcal_pkg::DTCAL_PHASES-1:0] gain_fault,
	input wire logic ramp_active,
	input wire logic [15:0] ramp_target_mv,
	output logic [15:0] ramp_setpoint_mv
);
	import dtcal_pkg::*;

	// ********************************************
	// storage
	// ********************************************
	logic [15:0] dead_time_limit_q;
	logic [DTCAL_PHASES-1:0][15:0] sense_gain_q;
	logic [DTCAL_PHASES-1:0][15:0] current_offset_q;
	logic [15:0] ramp_floor_voltage_q;

	logic [15:0] cmd_rdata_q;
	logic cmd_rvalid_q;
	logic cmd_ack_q;
	logic cmd_nack_q;
	logic [6:0] dt_hl_q;
	logic [6:0] dt_lh_q;
	logic [DTCAL_PHASES-1:0][31:0] current_q;
	logic [DTCAL_PHASES-1:0] current_valid_q;
	logic [DTCAL_PHASES-1:0] gain_fault_q;
	logic [15:0] ramp_setpoint_q;

	logic mapped;
	logic [15:0] rd_word;
	logic wr_ok;
	logic [6:0] lim_hl;
	logic [6:0] lim_lh;
	logic signed [39:0] floor_fix;
	logic signed [39:0] floor_int;
	logic [15:0] floor_mv;

	// ********************************************
	// command decode
	// ********************************************
	always_comb begin
		mapped = 1'b1;
		rd_word = 16'h0000;
		case (cmd_code)
			DTCAL_CMD_DEAD_TIME_LIMIT: rd_word = dead_time_limit_q & DTCAL_DT_USED_MASK;
			DTCAL_CMD_PHASE0_SENSE_GAIN: rd_word = sense_gain_q[0];
			DTCAL_CMD_PHASE1_SENSE_GAIN: rd_word = sense_gain_q[1];
			DTCAL_CMD_PHASE0_CURRENT_OFFSET: rd_word = current_offset_q[0];
			DTCAL_CMD_PHASE1_CURRENT_OFFSET: rd_word = current_offset_q[1];
			DTCAL_CMD_RAMP_FLOOR_VOLTAGE: rd_word = ramp_floor_voltage_q;
			default: mapped = 1'b0;
		endcase
	end

	// protected words refuse writes while protection is on
	assign wr_ok = cmd_wr && mapped && !write_protect;

	// ********************************************
	// register writes
	// ********************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			dead_time_limit_q <= DTCAL_RST_DEAD_TIME_LIMIT;
			ramp_floor_voltage_q <= DTCAL_RST_RAMP_FLOOR_VOLTAGE;
		end else if (wr_ok) begin
			if (cmd_code == DTCAL_CMD_DEAD_TIME_LIMIT) begin
				// unused bits are dropped at the write, so they can never steer anything
				dead_time_limit_q <= cmd_wdata & DTCAL_DT_USED_MASK;
			end
			if (cmd_code == DTCAL_CMD_RAMP_FLOOR_VOLTAGE) begin
				ramp_floor_voltage_q <= cmd_wdata;
			end
		end
	end

	genvar gp;
	generate
		for (gp = 0; gp < DTCAL_PHASES; gp++) begin : g_phase_regs
			always_ff @(posedge clk) begin
				if (srst) begin
					sense_gain_q[gp] <= DTCAL_RST_SENSE_GAIN;
					current_offset_q[gp] <= DTCAL_RST_CURRENT_OFFSET;
				end else if (wr_ok) begin
					if (cmd_code == DTCAL_CMD_PHASE0_SENSE_GAIN + 8'(gp)) begin
						sense_gain_q[gp] <= cmd_wdata;
					end
					if (cmd_code == DTCAL_CMD_PHASE0_CURRENT_OFFSET + 8'(gp)) begin
						current_offset_q[gp] <= cmd_wdata;
					end
				end
			end
		end
	endgenerate

	// ********************************************
	// read data and command status
	// ********************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			cmd_rdata_q <= 16'h0000;
			cmd_rvalid_q <= 1'b0;
			cmd_ack_q <= 1'b0;
			cmd_nack_q <= 1'b0;
		end else begin
			cmd_rvalid_q <= cmd_rd && mapped && !cmd_wr;
			cmd_rdata_q <= (cmd_rd && mapped && !cmd_wr) ? rd_word : 16'h0000;
			cmd_ack_q <= wr_ok || (cmd_rd && mapped && !cmd_wr);
			// both strobes at once is taken as a write; the read is dropped
			cmd_nack_q <= ((cmd_wr || cmd_rd) && !mapped) || (cmd_wr && mapped && write_protect);
		end
	end

	// ********************************************
	// dead-time limiting, shared by both phases
	// ********************************************
	// limits above the documented range are held at its top
	assign lim_hl = (dead_time_limit_q[DTCAL_DT_HL_MSB:DTCAL_DT_HL_LSB] > DTCAL_DT_RANGE_MAX_NS) ? DTCAL_DT_RANGE_MAX_NS
		: dead_time_limit_q[DTCAL_DT_HL_MSB:DTCAL_DT_HL_LSB];
	assign lim_lh = (dead_time_limit_q[DTCAL_DT_LH_MSB:DTCAL_DT_LH_LSB] > DTCAL_DT_RANGE_MAX_NS) ? DTCAL_DT_RANGE_MAX_NS
		: dead_time_limit_q[DTCAL_DT_LH_MSB:DTCAL_DT_LH_LSB];

	always_ff @(posedge clk) begin
		if (srst) begin
			dt_hl_q <= 7'h00;
			dt_lh_q <= 7'h00;
		end else if (adapt_en) begin
			dt_hl_q <= (adapt_hl_ns > lim_hl) ? lim_hl : adapt_hl_ns;
			dt_lh_q <= (adapt_lh_ns > lim_lh) ? lim_lh : adapt_lh_ns;
		end else begin
			dt_hl_q <= adapt_hl_ns;
			dt_lh_q <= adapt_lh_ns;
		end
	end

	// ********************************************
	// per-phase current calculation
	// ********************************************
	generate
		for (gp = 0; gp < DTCAL_PHASES; gp++) begin : g_phase_calc
			dtcal_phase_if pif ();

			// a strobe while the divider is busy is dropped; the next one catches up
			assign pif.start = sense_strobe && !pif.busy;
			assign pif.sense_uv = sense_uv[gp];
			assign pif.gain_word = sense_gain_q[gp];
			assign pif.offset_word = current_offset_q[gp];

			dtcal_phase_calc u_calc (
				.clk(clk),
				.srst(srst),
				.pif(pif)
			);

			always_ff @(posedge clk) begin
				if (srst) begin
					current_q[gp] <= 32'h00000000;
					current_valid_q[gp] <= 1'b0;
					gain_fault_q[gp] <= 1'b0;
				end else begin
					current_valid_q[gp] <= pif.done;
					if (pif.done) begin
						current_q[gp] <= pif.current_ma;
						gain_fault_q[gp] <= pif.fault;
					end
				end
			end
		end
	endgenerate

	// ********************************************
	// ramp floor
	// ********************************************
	assign floor_fix = dtcal_lin11_to_fix(ramp_floor_voltage_q);
	assign floor_int = floor_fix >>> DTCAL_FRAC_BITS;
	assign floor_mv = floor_int[39] ? 16'h0000 : ((floor_int[38:16] != 23'h000000) ? 16'hffff : floor_int[15:0]);

	always_ff @(posedge clk) begin
		if (srst) begin
			ramp_setpoint_q <= 16'h0000;
		end else if (ramp_active && ramp_target_mv < floor_mv) begin
			ramp_setpoint_q <= floor_mv;
		end else begin
			ramp_setpoint_q <= ramp_target_mv;
		end
	end

	// ********************************************
	// outputs
	// ********************************************
	assign cmd_rdata = cmd_rdata_q;
	assign cmd_rvalid = cmd_rvalid_q;
	assign cmd_ack = cmd_ack_q;
	assign cmd_nack = cmd_nack_q;
	assign dt_hl_ns = dt_hl_q;
	assign dt_lh_ns = dt_lh_q;
	assign current_ma = current_q;
	assign current_valid = current_valid_q;
	assign gain_fault = gain_fault_q;
	assign ramp_setpoint_mv = ramp_setpoint_q;

endmodule : dtcal_regs

/* testbench/dtcal_sva.sv */
// dtcal_sva: port-level assertions for the calibration register group
`timescale 1ns/1ps
module dtcal_sva (
	input wire logic clk,
	input wire logic srst,
	input wire logic [7:0] cmd_code,
	input wire logic cmd_wr,
	input wire logic cmd_rd,
	input wire logic [15:0] cmd_wdata,
	input wire logic write_protect,
	input wire logic [15:0] cmd_rdata,
	input wire logic cmd_rvalid,
	input wire logic cmd_ack,
	input wire logic cmd_nack,
	input wire logic adapt_en,
	input wire logic [6:0] adapt_hl_ns,
	input wire logic [6:0] adapt_lh_ns,
	input wire logic [6:0] dt_hl_ns,
	input wire logic [6:0] dt_lh_ns,
	input wire logic sense_strobe,
	input wire logic [dtcal_pkg::DTCAL_PHASES-1:0] current_valid,
	input wire logic ramp_active,
	input wire logic [15:0] ramp_target_mv,
	input wire logic [15:0] ramp_setpoint_mv
);
	import dtcal_pkg::*;
	// ********************************
	// access, dead time, current, floor
	// ********************************
	logic mapped;
	assign mapped = cmd_code inside {8'hbf, [8'hca:8'hce]};
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	sequence wr_s; cmd_wr && !write_protect && mapped; endsequence
	sequence rd_s; cmd_rd && !cmd_wr && mapped; endsequence

	wr_ack_a: assert property (wr_s |=> cmd_ack && !cmd_nack)
		else $error("accepted write not acknowledged");
	wp_nack_a: assert property (cmd_wr && write_protect |=> cmd_nack && !cmd_ack)
		else $error("protected write not refused");
	rd_data_a: assert property (rd_s |=> cmd_rvalid && cmd_ack)
		else $error("read gave no data");
	unmapped_nack_a: assert property ((cmd_wr || cmd_rd) && !mapped |=> cmd_nack && !cmd_rvalid)
		else $error("unmapped access not refused");
	write_readback_a: assert property (wr_s ##1 !cmd_wr ##1
		(rd_s and (cmd_code == $past(cmd_code, 2))) |=>
		cmd_rdata == ($past(cmd_code, 3) == 8'hbf ? $past(cmd_wdata, 3) & DTCAL_DT_USED_MASK : $past(cmd_wdata, 3)))
		else $error("read back differs from write");
	dt_spare_a: assert property (cmd_rvalid && $past(cmd_code) == 8'hbf |-> !cmd_rdata[15] && !cmd_rdata[7])
		else $error("unused dead time bits set");
	dt_limit_a: assert property (adapt_en |=> dt_hl_ns <= $past(adapt_hl_ns) && dt_lh_ns <= $past(adapt_lh_ns)
		&& dt_hl_ns <= DTCAL_DT_RANGE_MAX_NS && dt_lh_ns <= DTCAL_DT_RANGE_MAX_NS)
		else $error("dead time above limit");
	dt_pass_a: assert property (!adapt_en |=> dt_hl_ns == $past(adapt_hl_ns) && dt_lh_ns == $past(adapt_lh_ns))
		else $error("dead time request not passed");
	ramp_floor_a: assert property (1'b1 |=> ramp_setpoint_mv == $past(ramp_target_mv)
		|| $past(ramp_active) && ramp_setpoint_mv > $past(ramp_target_mv))
		else $error("ramp setpoint wrong");
	phase_step_a: assert property (current_valid[0] |-> current_valid[1] ##1 !current_valid[0])
		else $error("phase results out of step");
	calc_delay_a: assert property (current_valid[0] |-> $past(sense_strobe, 35))
		else $error("current result at wrong time");
endmodule : dtcal_sva

/* testbench/dtcal_host.sv */
// dtcal_host: management-side word master on the command port
`timescale 1ns/1ps
module dtcal_host (
	input wire logic clk,
	output logic [7:0] cmd_code,
	output logic cmd_wr,
	output logic cmd_rd,
	output logic [15:0] cmd_wdata,
	input wire logic [15:0] cmd_rdata,
	input wire logic cmd_rvalid,
	input wire logic cmd_ack,
	input wire logic cmd_nack
);
	initial begin
		cmd_code = 8'h00;
		cmd_wr = 1'b0;
		cmd_rd = 1'b0;
		cmd_wdata = 16'h0000;
	end
	// whole two-byte word per access, exponent/mantissa packed by caller
	task automatic xfer(input logic wr, input logic rd, input logic [7:0] code, input logic [15:0] data,
		output logic [15:0] rdata, output logic [2:0] resp);
		@(negedge clk);
		cmd_code = code;
		cmd_wr = wr;
		cmd_rd = rd;
		cmd_wdata = data;
		@(negedge clk);
		// answer stands only in the cycle after the taking edge
		rdata = cmd_rdata;
		resp = {cmd_ack, cmd_nack, cmd_rvalid};
		cmd_wr = 1'b0;
		cmd_rd = 1'b0;
		// released lines must not keep showing the last word
		cmd_code = ~code;
		cmd_wdata = ~data;
	endtask : xfer
endmodule : dtcal_host

/* testbench/tb.sv */
// tb: self-checking bench for the calibration register group
`timescale 1ns/1ps
module tb;
	import dtcal_pkg::*;
	// ********************************
	// wiring, checks and scenarios
	// ********************************
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic write_protect = 1'b0;
	logic adapt_en = 1'b0;
	logic [6:0] adapt_hl_ns = 7'h00, adapt_lh_ns = 7'h00, dt_hl_ns, dt_lh_ns;
	logic sense_strobe = 1'b0;
	logic [DTCAL_PHASES-1:0][15:0] sense_uv = '0;
	logic ramp_active = 1'b0;
	logic [15:0] ramp_target_mv = 16'h0000;
	logic [15:0] cmd_wdata, cmd_rdata, ramp_setpoint_mv;
	logic [7:0] cmd_code;
	logic cmd_wr, cmd_rd, cmd_rvalid, cmd_ack, cmd_nack;
	logic [DTCAL_PHASES-1:0][31:0] current_ma;
	logic [DTCAL_PHASES-1:0] current_valid, gain_fault;
	logic [7:0] codes [6] = '{8'hbf, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hce};
	int failures = 0;
	int compares = 0;

	always #50 clk = ~clk;

	dtcal_host i_host (.clk, .cmd_code, .cmd_wr, .cmd_rd, .cmd_wdata, .cmd_rdata, .cmd_rvalid, .cmd_ack, .cmd_nack);
	dtcal_regs i_dut (.clk, .srst, .cmd_code, .cmd_wr, .cmd_rd, .cmd_wdata, .write_protect, .cmd_rdata,
		.cmd_rvalid, .cmd_ack, .cmd_nack, .adapt_en, .adapt_hl_ns, .adapt_lh_ns, .dt_hl_ns, .dt_lh_ns,
		.sense_strobe, .sense_uv, .current_ma, .current_valid, .gain_fault, .ramp_active, .ramp_target_mv,
		.ramp_setpoint_mv);

	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t: value %h expected %h", $time, got, exp);
		end
	endtask : chk_val

	task automatic chk_resp(input logic [2:0] got, input logic [2:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t: response %b expected %b", $time, got, exp);
		end
	endtask : chk_resp

	task automatic wr(input logic [7:0] code, input logic [15:0] data, input logic [2:0] exp);
		logic [15:0] d;
		logic [2:0] r;
		i_host.xfer(1'b1, 1'b0, code, data, d, r);
		chk_resp(r, exp);
	endtask : wr

	task automatic rd(input logic [7:0] code, output logic [15:0] d);
		logic [2:0] r;
		i_host.xfer(1'b0, 1'b1, code, 16'h0000, d, r);
		chk_resp(r, 3'b101);
	endtask : rd

	task automatic t_reset_vals();
		logic [15:0] rv [6] = '{16'h3838, 16'haa66, 16'haa66, 16'h0000, 16'h0000, 16'hf258};
		logic [15:0] d;
		for (int i = 0; i < 6; i++) begin
			rd(codes[i], d);
			chk_val(32'(d), 32'(rv[i]));
		end
	endtask : t_reset_vals

	task automatic t_rw_protect();
		logic [15:0] d, w;
		logic [2:0] r;
		for (int i = 0; i < 6; i++) begin
			w = 16'hff00 | {8'h00, codes[i]};
			wr(codes[i], w, 3'b100);
			rd(codes[i], d);
			chk_val(32'(d), 32'(i == 0 ? w & 16'h7f7f : w));
			write_protect = 1'b1;
			wr(codes[i], ~w, 3'b010);
			write_protect = 1'b0;
			rd(codes[i], w);
			chk_val(32'(w), 32'(d));
		end
		wr(8'hc9, 16'h1234, 3'b010);
		i_host.xfer(1'b0, 1'b1, 8'hcf, 16'h0000, d, r);
		chk_resp(r, 3'b010);
		i_host.xfer(1'b1, 1'b1, 8'hcc, 16'h1234, d, r);
		chk_resp(r, 3'b100);
		rd(8'hcc, d);
		chk_val(32'(d), 32'h1234);
		write_protect = 1'b1;
		i_host.xfer(1'b1, 1'b1, 8'hcc, 16'h0000, d, r);
		chk_resp(r, 3'b010);
		write_protect = 1'b0;
	endtask : t_rw_protect

	task automatic dt_chk(input logic en, input logic [6:0] hl, lh, e_hl, e_lh);
		adapt_en = en;
		adapt_hl_ns = hl;
		adapt_lh_ns = lh;
		@(negedge clk);
		chk_val(32'(dt_hl_ns), 32'(e_hl));
		chk_val(32'(dt_lh_ns), 32'(e_lh));
	endtask : dt_chk

	task automatic t_dead_time();
		wr(8'hbf, 16'h2a14, 3'b100);
		dt_chk(1'b1, 7'h46, 7'h0a, 7'h2a, 7'h0a);
		dt_chk(1'b1, 7'h1e, 7'h19, 7'h1e, 7'h14);
		wr(8'hbf, 16'h7f7f, 3'b100);
		dt_chk(1'b1, 7'h64, 7'h64, 7'h3c, 7'h3c);
		dt_chk(1'b0, 7'h64, 7'h64, 7'h64, 7'h64);
	endtask : t_dead_time

	task automatic pulse_wait(output int n);
		sense_strobe = 1'b1;
		@(negedge clk);
		sense_strobe = 1'b0;
		n = 0;
		while (current_valid[0] !== 1'b1 && n < 60) begin
			@(negedge clk);
			n++;
		end
	endtask : pulse_wait

	task automatic t_current();
		int n;
		wr(8'hca, 16'h0001, 3'b100);
		wr(8'hcb, 16'h0002, 3'b100);
		wr(8'hcd, 16'h0001, 3'b100);
		wr(8'hcc, 16'h0000, 3'b100);
		sense_uv = {16'h03e8, 16'hfc18};
		pulse_wait(n);
		chk_val(32'(n), 32'(DTCAL_DIV_STEPS) + 32'h2);
		chk_val(current_ma[0], 32'hfffffc18);
		chk_val(current_ma[1], 32'h000005dc);
		chk_val(32'(gain_fault), 32'h0);
		wr(8'hca, 16'h0000, 3'b100);
		wr(8'hcc, 16'hffff, 3'b100);
		pulse_wait(n);
		chk_val(32'(current_valid), 32'h3);
		chk_val(current_ma[0], 32'hfffffe0c);
		chk_val(32'(gain_fault), 32'h1);
	endtask : t_current

	task automatic rp(input logic act, input logic [15:0] tgt, exp);
		ramp_active = act;
		ramp_target_mv = tgt;
		@(negedge clk);
		chk_val(32'(ramp_setpoint_mv), 32'(exp));
	endtask : rp

	task automatic t_ramp();
		wr(8'hce, 16'hf258, 3'b100);
		rp(1'b1, 16'h0064, 16'h0096);
		rp(1'b1, 16'h00c8, 16'h00c8);
		wr(8'hce, 16'h0064, 3'b100);
		rp(1'b1, 16'h0050, 16'h0064);
		rp(1'b0, 16'h0050, 16'h0050);
	endtask : t_ramp

	task automatic wrap_up();
		$display("failures=%0d compares=%0d", failures, compares);
		if (failures == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : wrap_up

	initial begin
		#1000000;
		failures++;
		wrap_up();
	end

	initial begin
		repeat (4) @(negedge clk);
		srst = 1'b0;
		t_reset_vals();
		t_rw_protect();
		t_dead_time();
		t_current();
		t_ramp();
		srst = 1'b1;
		repeat (2) @(negedge clk);
		srst = 1'b0;
		t_reset_vals();
		wrap_up();
	end
endmodule : tb

bind dtcal_regs dtcal_sva i_sva (.clk, .srst, .cmd_code, .cmd_wr, .cmd_rd, .cmd_wdata, .write_protect,
	.cmd_rdata, .cmd_rvalid, .cmd_ack, .cmd_nack, .adapt_en, .adapt_hl_ns, .adapt_lh_ns, .dt_hl_ns,
	.dt_lh_ns, .sense_strobe, .current_valid, .ramp_active, .ramp_target_mv, .ramp_setpoint_mv);
